// [utx_pkg.sv]
// package for the uart transmitter section: constants and carriers
package utx_pkg;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int unsigned BIT_TICKS   = 16;  // clocks per serial bit
    localparam int unsigned HALF_TICKS  = 8;   // clocks per half bit
    localparam int unsigned RESET_TICKS = 18;  // clocks to idle after reset
    localparam logic        LINE_IDLE   = 1'h1;
    localparam logic        FLAG_RESET  = 1'h1;

    // ****************************************************************
    // word length codes
    // ****************************************************************
    localparam logic [1:0] WL_5 = 2'h0;
    localparam logic [1:0] WL_6 = 2'h1;
    localparam logic [1:0] WL_7 = 2'h2;
    localparam logic [1:0] WL_8 = 2'h3;

    // frame format as seen by the shifter
    typedef struct packed {
        logic [1:0] word_len;      // {word_length_sel1, word_length_sel0}
        logic       parity_inhibit;
        logic       even_parity_select;
        logic       stop_bit_select;
    } utx_cfg_t;

    typedef struct packed {
        logic buffer_empty_flag;
        logic shift_empty_flag;
    } utx_status_t;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_START  = 5'h02,
        ST_DATA   = 5'h04,
        ST_PARITY = 5'h08,
        ST_STOP   = 5'h10
    } utx_state_t;
endpackage

// [utx_transmitter.sv]
// uart transmitter section: buffer, shifter and framing
`timescale 1ns/100ps
`default_nettype none

module utx_transmitter (
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic                master_reset_in,
    // host side
    input  wire logic [7:0]          tx_parallel_in,
    input  wire logic                buffer_load_strobe_n,
    input  wire utx_pkg::utx_cfg_t   cfg,
    output var  utx_pkg::utx_status_t status,
    // serial line
    output var  logic                serial_tx_out
);
    import utx_pkg::*;

    logic       rst_meta, rst_sync;
    logic [1:0] mr_sync, ld_sync;
    logic [7:0] din_meta, din_sync;
    utx_cfg_t   cfg_meta, cfg_sync;
    logic       ld_low, ld_low_d, ld_rise, mr;
    logic [7:0] buffer, shifter;
    logic       pending;
    utx_state_t state;
    logic [4:0] tick;
    logic [2:0] bit_idx;
    logic       par;
    logic       half_used;
    logic [4:0] rst_cnt;

    // ****************************************************************
    // reset release and input synchronisers
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // two stages each, third for edge detection on the strobe
    always_ff @(posedge core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            mr_sync  <= 2'h0;
            ld_sync  <= 2'h3;
            din_meta <= 8'h00;
            din_sync <= 8'h00;
            cfg_meta <= '0;
            cfg_sync <= '0;
            ld_low_d <= 1'b0;
        end else begin
            mr_sync  <= {mr_sync[0], master_reset_in};
            ld_sync  <= {ld_sync[0], buffer_load_strobe_n};
            din_meta <= tx_parallel_in;
            din_sync <= din_meta;
            cfg_meta <= cfg;
            cfg_sync <= cfg_meta;
            ld_low_d <= ld_low;
        end
    end

    assign mr      = mr_sync[1];
    assign ld_low  = ~ld_sync[1];
    assign ld_rise = ld_low_d & ~ld_low;

    // mask off unused high bits for short words
    function automatic logic [7:0] wl_mask(input logic [1:0] wl);
        case (wl)
            WL_5:    wl_mask = 8'h1F;
            WL_6:    wl_mask = 8'h3F;
            WL_7:    wl_mask = 8'h7F;
            default: wl_mask = 8'hFF;
        endcase
    endfunction

    // ****************************************************************
    // buffer register and buffer-empty flag
    // ****************************************************************
    // a transfer waits out a load edge so one character is not sent twice
    wire take = pending && (state == ST_IDLE) && !ld_low && !ld_rise && !mr;

    // capture while strobe low, right justified
    always_ff @(posedge core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            buffer <= 8'h00;
        end else if (ld_low) begin
            buffer <= din_sync & wl_mask(cfg_sync.word_len);
        end
    end

    // pending marks a full buffer
    always_ff @(posedge core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            pending <= 1'b0;
        end else if (mr) begin
            pending <= 1'b0;
        end else if (ld_rise) begin
            pending <= 1'b1;
        end else if (take) begin
            pending <= 1'b0;
        end
    end

    // ****************************************************************
    // shifter and framing
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            state     <= ST_IDLE;
            shifter   <= 8'h00;
            tick      <= 5'h00;
            bit_idx   <= 3'h0;
            par       <= 1'b0;
            half_used <= 1'b0;
        end else if (mr) begin
            state <= ST_IDLE;
            tick  <= 5'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    tick <= 5'h00;
                    if (take) begin
                        shifter   <= buffer;
                        par       <= ~cfg_sync.even_parity_select;
                        bit_idx   <= 3'h0;
                        half_used <= 1'b0;
                        state     <= ST_START;
                    end
                end
                ST_START, ST_DATA, ST_PARITY: begin
                    if (tick == 5'(BIT_TICKS - 1)) begin
                        tick <= 5'h00;
                        if (state == ST_START) begin
                            state <= ST_DATA;
                        end else if (state == ST_DATA) begin
                            par     <= par ^ shifter[0];
                            shifter <= {1'b0, shifter[7:1]};
                            bit_idx <= bit_idx + 3'h1;
                            if (bit_idx == {1'b1, cfg_sync.word_len}) begin
                                state <= cfg_sync.parity_inhibit ?
                                         ST_STOP : ST_PARITY;
                            end
                        end else begin
                            state <= ST_STOP;
                        end
                    end else begin
                        tick <= tick + 5'h01;
                    end
                end
                ST_STOP: begin
                    if (!cfg_sync.stop_bit_select &&
                        tick == 5'(BIT_TICKS - 1)) begin
                        state <= ST_IDLE;
                    end else if (cfg_sync.word_len == WL_5 &&
                        half_used && tick == 5'(HALF_TICKS - 1)) begin
                        state <= ST_IDLE;
                    end else if (half_used &&
                        tick == 5'(BIT_TICKS - 1)) begin
                        state <= ST_IDLE;
                    end else if (tick == 5'(BIT_TICKS - 1)) begin
                        tick      <= 5'h00;
                        half_used <= 1'b1;
                    end else begin
                        tick <= tick + 5'h01;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // master reset idle timer
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            rst_cnt <= 5'h00;
        end else if (mr) begin
            if (rst_cnt != 5'(RESET_TICKS)) begin
                rst_cnt <= rst_cnt + 5'h01;
            end
        end else begin
            rst_cnt <= 5'h00;
        end
    end

    // ****************************************************************
    // registered outputs
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            serial_tx_out            <= LINE_IDLE;
            status.buffer_empty_flag <= FLAG_RESET;
            status.shift_empty_flag  <= FLAG_RESET;
        end else begin
            case (state)
                ST_START:  serial_tx_out <= 1'b0;
                ST_DATA:   serial_tx_out <= shifter[0];
                ST_PARITY: serial_tx_out <= par;
                default:   serial_tx_out <= LINE_IDLE;
            endcase
            status.buffer_empty_flag <= ~(pending | ld_rise);
            status.shift_empty_flag  <= (state == ST_IDLE) & ~take;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_empty_drop;
        @(posedge core_clk) disable iff (!rst_sync)
        ld_rise && !mr |=> !status.buffer_empty_flag;
    endproperty
    a_empty_drop: assert property (p_empty_drop)
        else $error("buffer empty not cleared by load");

    property p_take_fast;
        @(posedge core_clk) disable iff (!rst_sync)
        ld_rise && state == ST_IDLE && !mr && !master_reset_in
        |-> ##[1:2] state == ST_START;
    endproperty
    a_take_fast: assert property (p_take_fast)
        else $error("idle shifter did not take buffer");

    property p_start_len;
        @(posedge core_clk) disable iff (!rst_sync || mr)
        $rose(state == ST_START) |-> (state == ST_START) [*8] ##1
        (state == ST_START) [*8] ##1 state == ST_DATA;
    endproperty
    a_start_len: assert property (p_start_len)
        else $error("start bit not sixteen clocks");

    property p_start_low;
        @(posedge core_clk) disable iff (!rst_sync)
        state == ST_START |=> !serial_tx_out;
    endproperty
    a_start_low: assert property (p_start_low)
        else $error("start bit not low");

    property p_hold_pending;
        @(posedge core_clk) disable iff (!rst_sync || mr)
        pending && state != ST_IDLE |=> pending;
    endproperty
    a_hold_pending: assert property (p_hold_pending)
        else $error("buffered character lost");

    property p_auto_move;
        @(posedge core_clk) disable iff (!rst_sync || mr)
        take |=> state == ST_START && !pending;
    endproperty
    a_auto_move: assert property (p_auto_move)
        else $error("pending character not moved");

    property p_idle_high;
        @(posedge core_clk) disable iff (!rst_sync)
        rst_cnt == 5'(RESET_TICKS) |-> serial_tx_out;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("line not high after master reset");

    property p_stop_high;
        @(posedge core_clk) disable iff (!rst_sync)
        state == ST_STOP |=> serial_tx_out;
    endproperty
    a_stop_high: assert property (p_stop_high)
        else $error("stop bit not high");

    property p_short_word;
        @(posedge core_clk) disable iff (!rst_sync)
        ld_low && cfg_sync.word_len == WL_5 |=> buffer[7:5] == 3'h0;
    endproperty
    a_short_word: assert property (p_short_word)
        else $error("upper inputs not ignored");
endmodule

`default_nettype wire

// [utx_host.sv]
// host model: writes characters through the active-low load strobe
`timescale 1ns/100ps
`default_nettype none
module utx_host (
    // clock
    input  wire logic       core_clk,
    // parallel character and load strobe
    output var  logic [7:0] tx_parallel_in,
    output var  logic       buffer_load_strobe_n
);
    // idle values at time zero
    initial begin
        tx_parallel_in       = 8'h00;
        buffer_load_strobe_n = 1'h1;
    end
    // strobe low three clocks, data held two clocks past the rise
    task automatic load(input logic [7:0] ch);
        @(posedge core_clk);
        tx_parallel_in       <= ch;
        buffer_load_strobe_n <= 1'h0;
        repeat (3) @(posedge core_clk);
        buffer_load_strobe_n <= 1'h1;
        repeat (2) @(posedge core_clk);
        tx_parallel_in       <= ~ch;   // hold over, stale bus inverted
    endtask
endmodule
`default_nettype wire

// [test_uart_transmitter_section.sv]
// testbench for the uart transmitter section
`timescale 1ns/100ps
`default_nettype none
module test_uart_transmitter_section;
    import utx_pkg::*;
    logic        core_clk = 1'h0;
    logic        rst_n;
    logic        master_reset_in;
    logic [7:0]  tx_parallel_in;
    logic        buffer_load_strobe_n;
    utx_cfg_t    cfg;
    utx_status_t status;
    logic        serial_tx_out;
    int          err_count = 0;
    int          comparisons = 0;
    int          cycles = 0;

    // ****************************************************************
    // clock, design and host
    // ****************************************************************
    always #4 core_clk = ~core_clk;
    utx_transmitter DUT (.core_clk(core_clk), .rst_n(rst_n),
        .master_reset_in(master_reset_in), .tx_parallel_in(tx_parallel_in),
        .buffer_load_strobe_n(buffer_load_strobe_n), .cfg(cfg),
        .status(status), .serial_tx_out(serial_tx_out));
    utx_host host (.core_clk(core_clk), .tx_parallel_in(tx_parallel_in),
        .buffer_load_strobe_n(buffer_load_strobe_n));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic end_sim;
        $display("comparisons %0d, errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic set_cfg(input logic [4:0] c);
        @(posedge core_clk);
        cfg <= utx_cfg_t'(c);
        repeat (4) @(posedge core_clk);
    endtask
    // receive one frame; gap measures stop length before the next start
    task automatic rx_frame(input logic [7:0] ch, input bit gap);
        int n;
        int sl;
        logic [7:0] d;
        d = ch & (8'hFF >> (2'h3 - cfg.word_len));
        sl = cfg.stop_bit_select ? ((cfg.word_len == WL_5) ? 24 : 32) : 16;
        n = 0;
        while (serial_tx_out !== 1'h0 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        repeat (8) @(negedge core_clk);
        chk("start", 8'h00, {7'h0, serial_tx_out});
        for (int i = 0; i < cfg.word_len + 5; i++) begin
            repeat (16) @(negedge core_clk);
            chk("data", {7'h0, d[i]}, {7'h0, serial_tx_out});
        end
        if (!cfg.parity_inhibit) begin
            repeat (16) @(negedge core_clk);
            chk("parity", {7'h0, ^d ^ ~cfg.even_parity_select},
                {7'h0, serial_tx_out});
        end
        repeat (16) @(negedge core_clk);
        chk("stop", 8'h01, {7'h0, serial_tx_out});
        if (gap) begin
            n = 0;
            while (serial_tx_out === 1'h1 && n < 40) begin
                @(negedge core_clk);
                n++;
            end
            chk("stop_len", 8'h01,
                {7'h0, n >= sl - 8 && n <= sl - 6});
        end
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_flags;
        bit saw;
        saw = 0;
        set_cfg({WL_8, 3'h0});
        host.load(8'h3C);
        repeat (6) begin
            @(negedge core_clk);
            if (status.buffer_empty_flag === 1'h0) saw = 1;
        end
        chk("buf_low", 8'h01, {7'h0, saw});
        chk("shift_empty", 8'h00, {7'h0, status.shift_empty_flag});
        chk("buf_empty", 8'h01, {7'h0, status.buffer_empty_flag});
        repeat (200) @(negedge core_clk);
        chk("shift_idle", 8'h01, {7'h0, status.shift_empty_flag});
    endtask
    task automatic t_formats;
        logic [4:0] tbl [4] = '{{WL_5, 3'h1}, {WL_6, 3'h2},
                                {WL_7, 3'h5}, {WL_8, 3'h0}};
        foreach (tbl[k]) begin
            set_cfg(tbl[k]);
            host.load(8'hA7);
            rx_frame(8'hA7, 0);
            repeat (40) @(negedge core_clk);
        end
    endtask
    task automatic t_back_to_back(input logic [4:0] c);
        set_cfg(c);
        host.load(8'h96);
        fork
            begin
                rx_frame(8'h96, 1);
                rx_frame(8'h4B, 0);
            end
            begin
                repeat (40) @(negedge core_clk);
                host.load(8'h4B);
                repeat (8) @(negedge core_clk);
                chk("pending", 8'h00,
                    {7'h0, status.buffer_empty_flag});
            end
        join
        repeat (40) @(negedge core_clk);
    endtask
    task automatic t_master_reset;
        int lows;
        lows = 0;
        set_cfg({WL_8, 3'h0});
        host.load(8'h00);
        repeat (60) @(posedge core_clk);
        master_reset_in <= 1'h1;
        repeat (20) @(posedge core_clk);
        master_reset_in <= 1'h0;
        repeat (18) @(negedge core_clk);
        chk("mr_line", 8'h01, {7'h0, serial_tx_out});
        repeat (200) begin
            @(negedge core_clk);
            if (serial_tx_out !== 1'h1) lows++;
        end
        chk("mr_quiet", 8'h00, lows[7:0]);
    endtask

    // main sequence
    initial begin
        rst_n           <= 1'h0;
        master_reset_in <= 1'h0;
        cfg             <= '0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'h1;
        repeat (4) @(negedge core_clk);
        chk("idle_line", 8'h01, {7'h0, serial_tx_out});
        chk("idle_flags", 8'h03, {6'h0, status});
        t_flags();
        t_formats();
        t_back_to_back({WL_5, 3'h1});
        t_back_to_back({WL_8, 3'h1});
        t_back_to_back({WL_6, 3'h6});
        t_master_reset();
        host.load(8'h5A);
        rx_frame(8'h5A, 0);
        end_sim();
    end
endmodule
`default_nettype wire
